// *** cisd_core.sv ***
// Decode and execute for subtract, soft trap, copies, test and clock halt.
// Assumes mem_rdata_i reflects the address held on bus_o in the same cycle.
`timescale 1ns/1ns
`include "cisd_defs.svh"
module cisd_core (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic [7:0]          mem_rdata_i,
  input  wire logic                irq_i,
  output cisd_pkg::cisd_bus_t      bus_o,
  output cisd_pkg::cisd_regs_t     regs_o,
  output logic                     halted_o
);
  import cisd_pkg::*;

  // ------------------------------------------------------------------
  // Decode table
  // ------------------------------------------------------------------
  function automatic cisd_dec_t decode(input logic [7:0] op);
    cisd_dec_t d;
    d.code = op;
    d.kind = CISD_K_NOP;
    d.mode = CISD_MD_NONE;
    d.need = `CISD_CYC_XFER;
    if (op[3:0] == `CISD_LO_SUB && op[7:4] >= 4'ha) begin
      d.kind = CISD_K_SUB;
      unique case (op[7:4])
        4'ha: begin d.mode = CISD_MD_LIT; d.need = `CISD_CYC_SUB_LIT; end
        4'hb: begin d.mode = CISD_MD_DIR; d.need = `CISD_CYC_SUB_DIR; end
        4'hc: begin d.mode = CISD_MD_FULL; d.need = `CISD_CYC_SUB_FULL; end
        4'hd: begin d.mode = CISD_MD_OFS16; d.need = `CISD_CYC_SUB_OFS16; end
        4'he: begin d.mode = CISD_MD_OFS8; d.need = `CISD_CYC_SUB_OFS8; end
        default: begin d.mode = CISD_MD_NOOFS; d.need = `CISD_CYC_SUB_NOOFS; end
      endcase
    end else if (op[3:0] == `CISD_LO_CHK && op[7:4] >= 4'h3 && op[7:4] <= 4'h7) begin
      d.kind = CISD_K_CHK;
      unique case (op[7:4])
        4'h3: begin d.mode = CISD_MD_DIR; d.need = `CISD_CYC_CHK_DIR; end
        4'h6: begin d.mode = CISD_MD_OFS8; d.need = `CISD_CYC_CHK_OFS8; end
        4'h7: begin d.mode = CISD_MD_NOOFS; d.need = `CISD_CYC_CHK_NOOFS; end
        default: begin d.mode = CISD_MD_NONE; d.need = `CISD_CYC_CHK_REG; end
      endcase
    end else if (op[7:4] == `CISD_HI_BTB) begin
      d.kind = CISD_K_BTB;
      d.mode = CISD_MD_BTB;
      d.need = `CISD_CYC_BTB;
    end else if (op == `CISD_OP_TRAP) begin
      d.kind = CISD_K_TRAP;
      d.need = `CISD_CYC_TRAP;
    end else if (op == `CISD_OP_A2X) begin
      d.kind = CISD_K_A2X;
    end else if (op == `CISD_OP_X2A) begin
      d.kind = CISD_K_X2A;
    end else if (op == `CISD_OP_WAIT) begin
      d.kind = CISD_K_WAIT;
    end
    return d;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  cisd_state_t state_q, state_d;
  cisd_regs_t  regs_q, regs_d;
  cisd_bus_t   bus_q, bus_d;
  cisd_dec_t   op_q, op_d, dec;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  hold_q, hold_d;
  logic [7:0]  rel_q, rel_d;
  logic [2:0]  idx_q, idx_d;
  logic        halted_q, halted_d;
  logic        fin;
  logic [3:0]  need;
  logic [7:0]  alu_l, alu_r, alu_q_diff;
  logic        alu_n, alu_z, alu_c;
  cisd_kind_t  kind_now;
  logic [7:0]  operand;

  assign dec = decode(mem_rdata_i);

  // ------------------------------------------------------------------
  // Arithmetic operand selection
  // ------------------------------------------------------------------
  always_comb begin
    kind_now = (state_q == CISD_ST_DECODE) ? dec.kind : op_q.kind;
    operand  = mem_rdata_i;
    if (state_q == CISD_ST_DECODE) begin
      operand = dec.code[4] ? regs_q.x : regs_q.a;
    end
    alu_l = (kind_now == CISD_K_SUB) ? regs_q.a : operand;
    alu_r = (kind_now == CISD_K_SUB) ? operand : 8'h00;
  end

  cisd_alu u_alu (
    .lhs_i    (alu_l),
    .rhs_i    (alu_r),
    .diff_o   (alu_q_diff),
    .neg_o    (alu_n),
    .zero_o   (alu_z),
    .borrow_o (alu_c)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    regs_d   = regs_q;
    op_d     = op_q;
    hold_d   = hold_q;
    rel_d    = rel_q;
    idx_d    = idx_q;
    halted_d = halted_q;
    bus_d    = bus_q;
    bus_d.rd = 1'b0;
    bus_d.wr = 1'b0;
    cnt_d    = cnt_q + 4'd1;
    fin      = 1'b0;
    need     = (state_q == CISD_ST_DECODE) ? dec.need : op_q.need;
    unique case (state_q)
      CISD_ST_DECODE: begin
        op_d      = dec;
        regs_d.pc = regs_q.pc + 16'd1;
        unique case (dec.kind)
          CISD_K_SUB, CISD_K_CHK, CISD_K_BTB: begin
            if (dec.mode == CISD_MD_NOOFS) begin
              bus_d.addr = {`CISD_PAGE0, regs_q.x};
              bus_d.rd   = 1'b1;
              state_d    = CISD_ST_READ;
            end else if (dec.mode == CISD_MD_NONE) begin
              regs_d.n = alu_n;
              regs_d.z = alu_z;
              fin      = 1'b1;
            end else begin
              bus_d.addr = regs_q.pc + 16'd1;
              bus_d.rd   = 1'b1;
              state_d    = CISD_ST_OP1;
            end
          end
          CISD_K_A2X: begin
            regs_d.x = regs_q.a;
            fin      = 1'b1;
          end
          CISD_K_X2A: begin
            regs_d.a = regs_q.x;
            fin      = 1'b1;
          end
          CISD_K_TRAP: begin
            idx_d   = 3'h0;
            state_d = CISD_ST_PUSH;
          end
          CISD_K_WAIT: begin
            regs_d.i = 1'b0;
            halted_d = 1'b1;
            state_d  = CISD_ST_HALT;
          end
          default: fin = 1'b1;
        endcase
      end
      CISD_ST_OP1: begin
        regs_d.pc = regs_q.pc + 16'd1;
        unique case (op_q.mode)
          CISD_MD_LIT: begin
            regs_d.a = alu_q_diff;
            regs_d.n = alu_n;
            regs_d.z = alu_z;
            regs_d.c = alu_c;
            fin      = 1'b1;
          end
          CISD_MD_DIR: begin
            bus_d.addr = {`CISD_PAGE0, mem_rdata_i};
            bus_d.rd   = 1'b1;
            state_d    = CISD_ST_READ;
          end
          CISD_MD_OFS8: begin
            bus_d.addr = {`CISD_PAGE0, regs_q.x} + {`CISD_PAGE0, mem_rdata_i};
            bus_d.rd   = 1'b1;
            state_d    = CISD_ST_READ;
          end
          default: begin
            hold_d     = mem_rdata_i;
            bus_d.addr = regs_q.pc + 16'd1;
            bus_d.rd   = 1'b1;
            state_d    = CISD_ST_OP2;
          end
        endcase
      end
      CISD_ST_OP2: begin
        regs_d.pc = regs_q.pc + 16'd1;
        bus_d.rd  = 1'b1;
        state_d   = CISD_ST_READ;
        if (op_q.mode == CISD_MD_FULL) begin
          bus_d.addr = {hold_q, mem_rdata_i};
        end else if (op_q.mode == CISD_MD_OFS16) begin
          bus_d.addr = {hold_q, mem_rdata_i} + {`CISD_PAGE0, regs_q.x};
        end else begin
          rel_d      = mem_rdata_i;
          bus_d.addr = {`CISD_PAGE0, hold_q};
        end
      end
      CISD_ST_READ: begin
        fin = 1'b1;
        if (op_q.kind == CISD_K_BTB) begin
          regs_d.c = mem_rdata_i[op_q.code[3:1]];
          if (mem_rdata_i[op_q.code[3:1]] != op_q.code[0]) begin
            regs_d.pc = regs_q.pc + {{8{rel_q[7]}}, rel_q};
          end
        end else begin
          regs_d.n = alu_n;
          regs_d.z = alu_z;
          if (op_q.kind == CISD_K_SUB) begin
            regs_d.a = alu_q_diff;
            regs_d.c = alu_c;
          end
        end
      end
      CISD_ST_PUSH: begin
        bus_d.addr = {`CISD_PAGE0, regs_q.sp};
        bus_d.wr   = 1'b1;
        regs_d.sp  = regs_q.sp - 8'd1;
        idx_d      = idx_q + 3'h1;
        unique case (idx_q)
          3'h0:    bus_d.wdata = regs_q.pc[7:0];
          3'h1:    bus_d.wdata = regs_q.pc[15:8];
          3'h2:    bus_d.wdata = regs_q.x;
          3'h3:    bus_d.wdata = regs_q.a;
          default: bus_d.wdata = {`CISD_FLAG_FILL, regs_q.h, regs_q.i,
                                  regs_q.n, regs_q.z, regs_q.c};
        endcase
        if (idx_q == `CISD_PUSH_LAST) begin
          regs_d.i = 1'b1;
          state_d  = CISD_ST_VECH;
        end
      end
      CISD_ST_VECH: begin
        bus_d.addr = `CISD_VEC_HI;
        bus_d.rd   = 1'b1;
        state_d    = CISD_ST_VECL;
      end
      CISD_ST_VECL: begin
        hold_d     = mem_rdata_i;
        bus_d.addr = `CISD_VEC_HI + 16'd1;
        bus_d.rd   = 1'b1;
        state_d    = CISD_ST_VECD;
      end
      CISD_ST_VECD: begin
        regs_d.pc = {hold_q, mem_rdata_i};
        fin       = 1'b1;
      end
      CISD_ST_HALT: begin
        // Only the core stalls; outside logic keeps its own clock
        if (irq_i) begin
          halted_d = 1'b0;
          fin      = 1'b1;
        end
      end
      CISD_ST_PAD: fin = 1'b1;
    endcase
    // Fetch of the next opcode overlaps the last cycle of this one
    if (fin) begin
      bus_d.addr = regs_d.pc;
      bus_d.rd   = 1'b1;
      if (cnt_q + 4'd1 >= need || state_q == CISD_ST_HALT) begin
        state_d = CISD_ST_DECODE;
        cnt_d   = 4'd0;
      end else begin
        state_d = CISD_ST_PAD;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q    <= CISD_ST_PAD;
      regs_q     <= '0;
      regs_q.pc  <= `CISD_PC_RESET;
      regs_q.sp  <= `CISD_SP_RESET;
      regs_q.i   <= 1'b1;
      bus_q      <= '0;
      op_q       <= '0;
      op_q.need  <= 4'd1;
      cnt_q      <= 4'd0;
      hold_q     <= 8'h00;
      rel_q      <= 8'h00;
      idx_q      <= 3'h0;
      halted_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      regs_q   <= regs_d;
      bus_q    <= bus_d;
      op_q     <= op_d;
      cnt_q    <= cnt_d;
      hold_q   <= hold_d;
      rel_q    <= rel_d;
      idx_q    <= idx_d;
      halted_q <= halted_d;
    end
  end

  assign bus_o    = bus_q;
  assign regs_o   = regs_q;
  assign halted_o = halted_q;
endmodule

// *** cisd_defs.svh ***
// Constants for the instruction subset decode and execute block.
// Assumes a byte-wide memory whose read data follow the registered address.
//
// How it works
// - Accumulator minus memory operand; update N Z C
// - Subtract cycles 2,3,4,5,4,3 per mode
// - Soft trap pushes five bytes, masks, vectors
// - Copy accumulator to index, flags untouched
// - Copy index to accumulator, flags untouched
// - Negative zero check: operand minus zero, no store
// - Full address: high byte then low byte
// - Offset16 indexed: high, low offset plus index
// - Bit test branch: address byte, then relative offset
`ifndef CISD_DEFS_SVH
`define CISD_DEFS_SVH

// ------------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------------
`define CISD_OP_TRAP       8'h83
`define CISD_OP_A2X        8'h97
`define CISD_OP_X2A        8'h9f
`define CISD_OP_WAIT       8'h8f
`define CISD_LO_SUB        4'h0
`define CISD_LO_CHK        4'hd
`define CISD_HI_BTB        4'h0

// ------------------------------------------------------------------
// Cycle counts
// ------------------------------------------------------------------
`define CISD_CYC_SUB_LIT   4'h2
`define CISD_CYC_SUB_DIR   4'h3
`define CISD_CYC_SUB_FULL  4'h4
`define CISD_CYC_SUB_OFS16 4'h5
`define CISD_CYC_SUB_OFS8  4'h4
`define CISD_CYC_SUB_NOOFS 4'h3
`define CISD_CYC_CHK_DIR   4'h4
`define CISD_CYC_CHK_REG   4'h3
`define CISD_CYC_CHK_OFS8  4'h5
`define CISD_CYC_CHK_NOOFS 4'h4
`define CISD_CYC_TRAP      4'ha
`define CISD_CYC_XFER      4'h2
`define CISD_CYC_BTB       4'h5

// ------------------------------------------------------------------
// Reset values and addresses
// ------------------------------------------------------------------
`define CISD_PC_RESET    16'h0000
`define CISD_SP_RESET    8'hff
`define CISD_VEC_HI      16'hfffc
`define CISD_FLAG_FILL   3'h7
`define CISD_PAGE0       8'h00
`define CISD_PUSH_LAST   3'h4

`endif

// *** cisd_pkg.sv ***
// Types shared by the decode and execute logic, its memory model and its port checker.
// Assumes cisd_defs.svh for all numeric constants.
package cisd_pkg;

  typedef enum logic [3:0] {
    CISD_ST_DECODE, CISD_ST_OP1, CISD_ST_OP2, CISD_ST_READ, CISD_ST_PUSH,
    CISD_ST_VECH, CISD_ST_VECL, CISD_ST_VECD, CISD_ST_PAD, CISD_ST_HALT
  } cisd_state_t;

  typedef enum logic [2:0] {
    CISD_MD_LIT, CISD_MD_DIR, CISD_MD_FULL, CISD_MD_OFS16,
    CISD_MD_OFS8, CISD_MD_NOOFS, CISD_MD_NONE, CISD_MD_BTB
  } cisd_mode_t;

  typedef enum logic [2:0] {
    CISD_K_SUB, CISD_K_CHK, CISD_K_A2X, CISD_K_X2A,
    CISD_K_TRAP, CISD_K_WAIT, CISD_K_BTB, CISD_K_NOP
  } cisd_kind_t;

  typedef struct packed {
    cisd_kind_t kind;
    cisd_mode_t mode;
    logic [3:0] need;
    logic [7:0] code;
  } cisd_dec_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  a;
    logic [7:0]  x;
    logic        h;
    logic        i;
    logic        n;
    logic        z;
    logic        c;
  } cisd_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } cisd_bus_t;

endpackage

// *** cisd_alu.sv ***
// Eight-bit subtractor with negative, zero and borrow flags.
// Assumes operands are stable within the cycle; purely combinational.
`timescale 1ns/1ns
module cisd_alu (
  input  wire logic [7:0] lhs_i,
  input  wire logic [7:0] rhs_i,
  output logic      [7:0] diff_o,
  output logic            neg_o,
  output logic            zero_o,
  output logic            borrow_o
);
  logic [8:0] wide;

  always_comb begin
    wide     = {1'b0, lhs_i} - {1'b0, rhs_i};
    diff_o   = wide[7:0];
    neg_o    = wide[7];
    zero_o   = (wide[7:0] == 8'h00);
    borrow_o = wide[8];
  end
endmodule

// *** cisd_core_monitor.sv ***
// Concurrent checks on the decode and execute core ports.
// Assumes a single clock domain and the synchronous reset of the core.
`timescale 1ns/1ns
module cisd_core_monitor (
  input wire logic                 clk_i,
  input wire logic                 reset_i,
  input wire logic [7:0]           mem_rdata_i,
  input wire logic                 irq_i,
  input wire cisd_pkg::cisd_bus_t  bus_o,
  input wire cisd_pkg::cisd_regs_t regs_o,
  input wire logic                 halted_o
);
  import cisd_pkg::*;
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_half_stable: assert property (1'b1 |=> $stable(regs_o.h))
    else $error("half carry moved");
  a_copy_flags: assert property ($changed(regs_o.x) |->
    regs_o.x == regs_o.a && $stable({regs_o.n, regs_o.z, regs_o.c}))
    else $error("index copy wrong");
  a_stack_page: assert property (bus_o.wr |-> bus_o.addr[15:8] == 8'h00)
    else $error("push outside page zero");
  a_push_burst: assert property ($rose(bus_o.wr) |-> bus_o.wr [*5] ##1 !bus_o.wr)
    else $error("push count wrong");
  a_push_down: assert property (bus_o.wr && $past(bus_o.wr) |->
    bus_o.addr == $past(bus_o.addr) - 16'h0001)
    else $error("push order wrong");
  a_trap_vector: assert property ($fell(bus_o.wr) |-> bus_o.rd &&
    bus_o.addr == 16'hfffc ##1 bus_o.addr == 16'hfffd ##[1:3] regs_o.i)
    else $error("vector fetch wrong");
  a_halt_mask: assert property ($rose(halted_o) |-> !regs_o.i)
    else $error("mask not cleared");
  a_halt_hold: assert property (halted_o && !irq_i |=> halted_o)
    else $error("left halt early");
  a_halt_wake: assert property (halted_o && irq_i |-> ##[1:2] !halted_o)
    else $error("no wake");

  c_push: cover property ($rose(bus_o.wr));
  c_halt: cover property ($rose(halted_o));
  c_wake: cover property (halted_o && irq_i);
endmodule

bind cisd_core cisd_core_monitor u_mon (
  .clk_i      (clk_i),
  .reset_i    (reset_i),
  .mem_rdata_i(mem_rdata_i),
  .irq_i      (irq_i),
  .bus_o      (bus_o),
  .regs_o     (regs_o),
  .halted_o   (halted_o)
);

// *** cisd_mem_model.sv ***
// Byte memory on the core's registered address, no wait states.
// Assumes the bench preloads the array directly while the core is in reset or halted.
`timescale 1ns/1ns
module cisd_mem_model (
  input  wire logic                clk_i,
  input  wire cisd_pkg::cisd_bus_t bus_i,
  output logic [7:0]               rdata_o
);
  import cisd_pkg::*;
  logic [7:0] m [0:65535];
  always @(posedge clk_i) begin
    if (bus_i.wr) begin
      m[bus_i.addr] <= bus_i.wdata;
    end
  end
  // Inverse when idle, so a stale byte never passes for a read
  assign rdata_o = bus_i.rd ? m[bus_i.addr] : ~m[bus_i.addr];
endmodule

// *** cpu_instruction_subset_decode_tb.sv ***
// Self-checking bench: short programs end in clock halt, cycles are counted.
// Assumes the memory model and the bound port checker.
`timescale 1ns/1ns
module cpu_instruction_subset_decode_tb;
  import cisd_pkg::*;
  logic       clk;
  logic       rst = 1'b1;
  logic       irq = 1'b0;
  logic [7:0] rdata;
  cisd_bus_t  bus;
  cisd_regs_t regs;
  logic       halted;
  int         fails = 0;
  int         checked = 0;
  int         cnt;
  int         base;

  cisd_core uut (
    .clk_i      (clk),
    .reset_i    (rst),
    .mem_rdata_i(rdata),
    .irq_i      (irq),
    .bus_o      (bus),
    .regs_o     (regs),
    .halted_o   (halted)
  );
  cisd_mem_model mem (.clk_i(clk), .bus_i(bus), .rdata_o(rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // Prefix a=x=fd, then slot bytes, then halt; cycles counted to halt
  task automatic run(input logic [39:0] s, input int n);
    @(posedge clk);
    rst <= 1'b1;
    foreach (mem.m[k]) mem.m[k] = 8'h00;
    {mem.m[0], mem.m[1], mem.m[2]} = 24'ha00397;
    {mem.m[16'h40], mem.m[16'h41], mem.m[16'h1234]} = 24'h2200fd;
    {mem.m[16'h10fd], mem.m[16'h011d], mem.m[16'h00fd]} = 24'hfe0180;
    {mem.m[16'hfffc], mem.m[16'hfffd], mem.m[16'h0200]} = 24'h02008f;
    for (int k = 0; k < n; k++) mem.m[3+k] = s[39-8*k -: 8];
    mem.m[3+n] = 8'h8f;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cnt = 0;
    while (halted !== 1'b1 && cnt < 400) begin
      @(posedge clk);
      #1 cnt++;
    end
  endtask

  task automatic op(input logic [39:0] s, input int n, input int cyc,
                    input logic [7:0] ea, input logic [7:0] ex, input logic [2:0] ef);
    run(s, n);
    chk(cnt - base == cyc, "cycle count");
    chk(regs.a === ea && regs.x === ex, "a or x");
    chk({regs.n, regs.z, regs.c} === ef, "flags");
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_sub;
    op(40'ha011000000, 2, 2, 8'hec, 8'hfd, 3'b100);
    op(40'hb040000000, 2, 3, 8'hdb, 8'hfd, 3'b100);
    op(40'hc012340000, 3, 4, 8'h00, 8'hfd, 3'b010);
    op(40'hd010000000, 3, 5, 8'hff, 8'hfd, 3'b101);
    op(40'he020000000, 2, 4, 8'hfc, 8'hfd, 3'b100);
    op(40'hf000000000, 1, 3, 8'h7d, 8'hfd, 3'b000);
    $display("subtract modes done");
  endtask

  task t_tst;
    op(40'h3d41000000, 2, 4, 8'hfd, 8'hfd, 3'b011);
    op(40'h4d00000000, 1, 3, 8'hfd, 8'hfd, 3'b101);
    op(40'h5d00000000, 1, 3, 8'hfd, 8'hfd, 3'b101);
    op(40'h6d20000000, 2, 5, 8'hfd, 8'hfd, 3'b001);
    op(40'h7d00000000, 1, 4, 8'hfd, 8'hfd, 3'b101);
    $display("test modes done");
  endtask

  task t_copy_branch;
    op(40'ha010970000, 3, 4, 8'hed, 8'hed, 3'b100);
    op(40'ha0109f0000, 3, 4, 8'hfd, 8'hfd, 3'b100);
    op(40'h014102a001, 5, 5, 8'hfd, 8'hfd, 3'b100);
    op(40'h004102a001, 5, 7, 8'hfc, 8'hfd, 3'b100);
    $display("copies and branches done");
  endtask

  task t_trap;
    op(40'h8300000000, 1, 10, 8'hfd, 8'hfd, 3'b101);
    chk({mem.m[255], mem.m[254], mem.m[253], mem.m[252], mem.m[251]}
        === 40'h0400fdfded, "stacked bytes");
    chk(regs.sp === 8'hfa, "stack pointer");
    chk(regs.pc === 16'h0201 && regs.i === 1'b0, "vector taken");
    $display("soft trap done");
  endtask

  task t_wake;
    run(40'h0, 0);
    chk(regs.i === 1'b0, "mask after halt");
    {mem.m[4], mem.m[5], mem.m[6]} = 24'ha0018f;
    repeat (4) @(posedge clk);
    #1 chk(halted === 1'b1, "halt held");
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    cnt = 0;
    while (halted !== 1'b1 && cnt < 20 || cnt == 0) begin
      @(posedge clk);
      #1 cnt++;
    end
    chk(regs.a === 8'hfc && cnt > 2 && cnt < 20, "resume after wake");
    $display("halt and wake done");
  endtask

  task results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #60000;
    fails++;
    results();
  end

  initial begin
    run(40'h0, 0);
    base = cnt;
    chk(halted === 1'b1 && regs.a === 8'hfd, "prefix program");
    chk(regs.pc === 16'h0004 && regs.sp === 8'hff, "prefix pc and sp");
    t_sub();
    t_tst();
    t_copy_branch();
    t_trap();
    t_wake();
    results();
  end
endmodule
